// ===== verilog/ocs_pkg.sv
// package: timing constants and states for the offset trim sequencer
package ocs_pkg;
   // clock rate
   localparam int CLK_MHZ = 250;
   // pin-started turn-on time, in microseconds
   localparam int PIN_TURN_ON_US = 5000;
   // supply turn-on time, in microseconds
   localparam int SUPPLY_TURN_ON_US = 200000;
   // settling part of the pin-started turn-on time, in microseconds
   localparam int SETTLE_US = 1000;
   // derived cycle counts
   localparam int PIN_TURN_ON_CYC = PIN_TURN_ON_US * CLK_MHZ;
   localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
   localparam int SUPPLY_TURN_ON_CYC = SUPPLY_TURN_ON_US * CLK_MHZ;
   localparam int CORRECT_CYC = PIN_TURN_ON_CYC - SETTLE_CYC;
   localparam int SUPPLY_DELAY_CYC = SUPPLY_TURN_ON_CYC - PIN_TURN_ON_CYC;
   localparam int CNT_W = 26;
   localparam int TRIM_W = 8;
   localparam logic [TRIM_W-1:0] TRIM_RESET = 8'h80;
   typedef enum logic [2:0] {
      OCS_LOW_POWER,
      OCS_SUPPLY_WAIT,
      OCS_SETTLE,
      OCS_CORRECT,
      OCS_STORE,
      OCS_NORMAL
   } ocs_state_type;
endpackage : ocs_pkg

// ===== verilog/ocs_offset_cal_sequencer.sv
// offset trim sequencer for one select pin and its amplifier group
// Summary of operation
// [RULE_01] select high: low power, output high impedance
// [RULE_02] select falling low launches a trim sequence
// [RULE_03] trim done: output low impedance, normal
// [RULE_04] supply monitor starts trim at power-on, brown-out
// [RULE_05] settling delay first, then offset correction
// [RULE_06] trim triggers from supply monitor and parity
// [RULE_07] during trim: output hi-z, inputs internally routed
// [RULE_08] state machine stores trim constants before normal
// [RULE_09] pin-started turn-on about 5 ms
// [RULE_10] undriven select pin reads low (on-chip pull-down)
// [RULE_11] controller spaces two-pin toggles apart
// [RULE_12] controller avoids toggles during other trim
// [RULE_13] low supply enters low-power mode
// [RULE_14] supply recovery: delay then trim, 200 ms total
// [RULE_15] parity error: supply event, full turn-on time
// [RULE_16] divider connected only during trim
// [RULE_17] quad parts: one instance per amplifier pair
// [RULE_18] synchronised select, delays as cycle counts
// [RULE_19] request during trim restarts from settling
module ocs_offset_cal_sequencer
   import ocs_pkg::*;
#(
   parameter int SETTLE_CYCLES = SETTLE_CYC,
   parameter int CORRECT_CYCLES = CORRECT_CYC,
   parameter int SUPPLY_DELAY_CYCLES = SUPPLY_DELAY_CYC
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic cal_select_pin_i, // RULE_17
   input wire logic supply_low_i,
   input wire logic parity_error_i,
   input wire logic [TRIM_W-1:0] measured_trim_i,
   output logic low_power_o,
   output logic output_hiz_o,
   output logic inputs_isolated_o,
   output logic divider_connect_o,
   output logic trim_busy_o,
   output logic trim_write_o,
   output logic [TRIM_W-1:0] trim_const_o
);
   //---------------------------------------------------------------
   // select pin synchroniser
   //---------------------------------------------------------------
   logic sel_meta;
   logic sel_sync;
   logic sel_prev;
   logic sel_fall;
   // two flops before use; pull-down keeps undriven pin low
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         sel_meta <= 1'b0;
         sel_sync <= 1'b0;
         sel_prev <= 1'b0;
      end else begin
         sel_meta <= cal_select_pin_i; // RULE_18 RULE_10
         sel_sync <= sel_meta;
         sel_prev <= sel_sync;
      end
   end
   assign sel_fall = sel_prev & ~sel_sync; // RULE_02

   //---------------------------------------------------------------
   // sequencer
   //---------------------------------------------------------------
   ocs_state_type state;
   logic [CNT_W-1:0] count;
   logic supply_prev;
   logic supply_restore;
   assign supply_restore = supply_prev & ~supply_low_i;

   // supply monitor edge tracking; reset counts as supply-low
   always_ff @(posedge core_clk_i) begin
      if (reset_i) supply_prev <= 1'b1;
      else supply_prev <= supply_low_i;
   end

   // main state machine with cycle counter
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         state <= OCS_LOW_POWER; // RULE_04
         count <= '0;
      end else if (supply_low_i) begin
         state <= OCS_LOW_POWER; // RULE_13
         count <= '0;
      end else if (parity_error_i || supply_restore) begin
         state <= OCS_SUPPLY_WAIT; // RULE_15 RULE_14 RULE_06
         count <= '0;
      end else if (sel_sync) begin
         state <= OCS_LOW_POWER; // RULE_01
         count <= '0;
      end else if (sel_fall) begin
         state <= OCS_SETTLE; // RULE_02 RULE_19
         count <= '0;
      end else begin
         count <= count + 1'b1;
         case (state)
            OCS_LOW_POWER: count <= '0;
            OCS_SUPPLY_WAIT: begin
               if (count == CNT_W'(SUPPLY_DELAY_CYCLES - 1)) begin
                  state <= OCS_SETTLE; // RULE_14
                  count <= '0;
               end
            end
            OCS_SETTLE: begin
               if (count == CNT_W'(SETTLE_CYCLES - 1)) begin
                  state <= OCS_CORRECT; // RULE_05
                  count <= '0;
               end
            end
            OCS_CORRECT: begin
               if (count == CNT_W'(CORRECT_CYCLES - 2)) begin
                  state <= OCS_STORE; // RULE_09
                  count <= '0;
               end
            end
            OCS_STORE: begin
               state <= OCS_NORMAL; // RULE_03 RULE_08
               count <= '0;
            end
            OCS_NORMAL: count <= '0;
            default: begin
               state <= OCS_LOW_POWER;
               count <= '0;
            end
         endcase
      end
   end

   // trim constant memory, written at the store step
   always_ff @(posedge core_clk_i) begin
      if (reset_i) trim_const_o <= TRIM_RESET;
      else if (state == OCS_STORE) trim_const_o <= measured_trim_i; // RULE_08
   end

   // registered one-cycle write strobe
   always_ff @(posedge core_clk_i) begin
      if (reset_i) trim_write_o <= 1'b0;
      else trim_write_o <= (state == OCS_STORE); // RULE_08
   end

   // mode outputs decoded from state
   always_comb begin
      trim_busy_o = (state == OCS_SETTLE) || (state == OCS_CORRECT) || (state == OCS_STORE);
      low_power_o = (state == OCS_LOW_POWER) || (state == OCS_SUPPLY_WAIT); // RULE_01 RULE_13
      output_hiz_o = (state != OCS_NORMAL); // RULE_01 RULE_07 RULE_03
      inputs_isolated_o = trim_busy_o; // RULE_07
      divider_connect_o = trim_busy_o; // RULE_16
   end

   //---------------------------------------------------------------
   // assertions
   //---------------------------------------------------------------
   // helper: run length of consecutive busy cycles for the turn-on check
   logic [CNT_W-1:0] busy_run;
   always_ff @(posedge core_clk_i) begin
      if (reset_i) busy_run <= '0;
      else if (trim_busy_o) busy_run <= busy_run + 1'b1;
      else busy_run <= '0;
   end

   // no trigger that outranks the running step
   logic no_event;
   assign no_event = !supply_low_i && !parity_error_i && !supply_restore
      && !sel_sync && !sel_fall;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   // mode, routing and sequencing checks
   hiz_normal_a: assert property ($rose(!output_hiz_o) |-> trim_write_o) // RULE_03
      else $error("output left high impedance without a fresh trim");
   lp_select_a: assert property (sel_sync && !supply_low_i && !parity_error_i // RULE_01
      && !supply_restore |=> low_power_o && output_hiz_o)
      else $error("select high did not give low power");
   fall_launch_a: assert property (sel_fall && !sel_sync && !supply_low_i // RULE_02
      && !parity_error_i && !supply_restore |=> state == OCS_SETTLE && count == 0)
      else $error("select fall did not launch trim");
   settle_first_a: assert property ($rose(state == OCS_CORRECT) // RULE_05
      |-> $past(state) == OCS_SETTLE)
      else $error("correction without settling");
   store_write_a: assert property (state == OCS_STORE && no_event // RULE_08
      |=> trim_write_o && state == OCS_NORMAL)
      else $error("store did not write and resume");
   trim_route_a: assert property (trim_busy_o |-> inputs_isolated_o && output_hiz_o // RULE_07
      && !low_power_o)
      else $error("trim routing wrong");
   divider_a: assert property (divider_connect_o == trim_busy_o) // RULE_16
      else $error("divider connected outside trim");
   supply_low_a: assert property (supply_low_i |=> low_power_o) // RULE_13
      else $error("low supply not low power");
   parity_a: assert property (parity_error_i && !supply_low_i // RULE_15
      |=> state == OCS_SUPPLY_WAIT)
      else $error("parity error not handled");
   restart_a: assert property ($past(trim_busy_o) && sel_fall && !sel_sync // RULE_19
      && !supply_low_i && !parity_error_i && !supply_restore
      |=> state == OCS_SETTLE && count == 0)
      else $error("restart lost");

   // timing and trim memory checks
   supply_wait_a: assert property (state == OCS_SUPPLY_WAIT && no_event // RULE_14
      && count == CNT_W'(SUPPLY_DELAY_CYCLES - 1) |=> state == OCS_SETTLE)
      else $error("supply delay length wrong");
   settle_len_a: assert property (state == OCS_SETTLE && no_event // RULE_05
      && count == CNT_W'(SETTLE_CYCLES - 1) |=> state == OCS_CORRECT)
      else $error("settling delay length wrong");
   correct_len_a: assert property (state == OCS_CORRECT && no_event // RULE_09
      && count == CNT_W'(CORRECT_CYCLES - 2) |=> state == OCS_STORE)
      else $error("correction length wrong");
   turn_on_a: assert property ($rose(state == OCS_NORMAL) // RULE_09
      |-> busy_run == CNT_W'(SETTLE_CYCLES + CORRECT_CYCLES))
      else $error("pin turn-on length wrong");
   write_pulse_a: assert property (trim_write_o |=> !trim_write_o) // RULE_08
      else $error("trim write strobe longer than one cycle");
   trim_hold_a: assert property ($changed(trim_const_o) |-> trim_write_o) // RULE_08
      else $error("trim constant changed without a write");

   // main scenarios
   pin_trim_c: cover property (sel_fall ##1 state == OCS_SETTLE);
   supply_trim_c: cover property (supply_restore ##1 state == OCS_SUPPLY_WAIT);
   parity_trim_c: cover property (parity_error_i && trim_busy_o);
   restart_c: cover property ($past(trim_busy_o) && sel_fall);
   resume_c: cover property (state == OCS_STORE ##1 state == OCS_NORMAL);
endmodule : ocs_offset_cal_sequencer

// ===== tb/ocs_ctrl_model.sv
// controller model driving one select pin, with the on-chip pull-down
module ocs_ctrl_model (
   input wire logic drive_en_i,
   input wire logic level_i,
   output logic cal_select_pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // released pin falls to the pull-down level; one pin only, no cross-pin gaps
   assign cal_select_pin_o = drive_en_i ? level_i : 1'h0;
endmodule // ocs_ctrl_model

// ===== tb/tb_offset_cal_sequencer.sv
// self-checking testbench for the offset trim sequencer
module tb_offset_cal_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   import ocs_pkg::*;
   localparam int SC = 4;
   localparam int CC = 6;
   localparam int DC = 10;
   logic core_clk_i = 1'h0;
   logic reset_i = 1'h1;
   logic supply_low_i = 1'h0;
   logic parity_error_i = 1'h0;
   logic drive_en = 1'h0;
   logic drive_level = 1'h1;
   logic [TRIM_W-1:0] measured_trim_i = 8'h00;
   logic sel_pin, low_power_o, output_hiz_o, inputs_isolated_o;
   logic divider_connect_o, trim_busy_o, trim_write_o;
   logic [TRIM_W-1:0] trim_const_o;
   logic [TRIM_W-1:0] m;
   int mismatches = 0;
   int num_checks = 0;
   int cycles = 0;
   int hold;
   integer seed = 95580;
   // ------------------------------
   // clock, partner and design
   // ------------------------------
   always #2 core_clk_i = ~core_clk_i;
   ocs_ctrl_model ctrl (.drive_en_i(drive_en), .level_i(drive_level), .cal_select_pin_o(sel_pin));
   ocs_offset_cal_sequencer #(.SETTLE_CYCLES(SC), .CORRECT_CYCLES(CC),
      .SUPPLY_DELAY_CYCLES(DC)) uut (.core_clk_i(core_clk_i), .reset_i(reset_i),
      .cal_select_pin_i(sel_pin), .supply_low_i(supply_low_i),
      .parity_error_i(parity_error_i), .measured_trim_i(measured_trim_i),
      .low_power_o(low_power_o), .output_hiz_o(output_hiz_o),
      .inputs_isolated_o(inputs_isolated_o), .divider_connect_o(divider_connect_o),
      .trim_busy_o(trim_busy_o), .trim_write_o(trim_write_o), .trim_const_o(trim_const_o));
   // ------------------------------
   // checking helpers
   // ------------------------------
   function automatic int busy_len();
      return SC + CC;
   endfunction
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task give_verdict;
      if (mismatches == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // follow one trim from its trigger edge to normal operation
   task automatic run_trim(input int exp_lp);
      int lp, bz, iso;
      m = TRIM_W'($random(seed));
      measured_trim_i = m;
      lp = 0;
      bz = 0;
      iso = 0;
      @(negedge core_clk_i);
      parity_error_i = 1'h0;
      for (int n = 0; n < 100 && output_hiz_o !== 1'h0; n++) begin
         lp += (low_power_o === 1'h1);
         bz += (trim_busy_o === 1'h1);
         iso += (trim_busy_o === 1'h1 && {inputs_isolated_o, divider_connect_o,
            output_hiz_o, low_power_o} !== 4'hE);
         @(negedge core_clk_i);
      end
      check("lp_cycles", exp_lp, lp);
      check("busy_cycles", busy_len(), bz);
      check("iso_bad", 0, iso);
      check("write", 1'h1, trim_write_o);
      check("trim", m, trim_const_o);
      check("lp_norm", 1'h0, low_power_o);
      check("div_norm", 1'h0, divider_connect_o);
   endtask
   // timeout guard
   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches++;
         give_verdict;
      end
   end
   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      repeat (16) @(negedge core_clk_i);
      check("trim_rst", TRIM_RESET, trim_const_o);
      check("lp_rst", 1'h1, low_power_o);
      reset_i = 1'h0;
      run_trim(DC);
      for (int i = 0; i < 5; i++) begin
         hold = 1 + ($random(seed) & 7);
         drive_level = 1'h1;
         drive_en = 1'h1;
         repeat (hold + 3) @(negedge core_clk_i);
         check("lp_sel", 1'h1, low_power_o);
         check("hiz_sel", 1'h1, output_hiz_o);
         check("div_sel", 1'h0, divider_connect_o);
         // release the pin or drive it low, at random
         drive_level = 1'h0;
         drive_en = 1'($random(seed));
         run_trim(2);
      end
      drive_level = 1'h1;
      drive_en = 1'h1;
      repeat (4) @(negedge core_clk_i);
      drive_en = 1'h0;
      repeat (8) @(negedge core_clk_i);
      check("busy_mid", 1'h1, trim_busy_o);
      parity_error_i = 1'h1;
      run_trim(DC);
      // one-cycle select pulse in mid-correction restarts through low power
      drive_en = 1'h1;
      repeat (4) @(negedge core_clk_i);
      drive_en = 1'h0;
      repeat (8) @(negedge core_clk_i);
      drive_en = 1'h1;
      @(negedge core_clk_i);
      drive_en = 1'h0;
      repeat (2) @(negedge core_clk_i);
      check("lp_restart", 1'h1, low_power_o);
      run_trim(0);
      supply_low_i = 1'h1;
      repeat (3) @(negedge core_clk_i);
      check("lp_low", 1'h1, low_power_o);
      check("hiz_low", 1'h1, output_hiz_o);
      supply_low_i = 1'h0;
      run_trim(DC);
      give_verdict;
   end
endmodule // tb_offset_cal_sequencer
